// ===== dfl_regs.svh
// register offsets, field positions, reset values and sizes of the fixed-latency delay line
`ifndef DFL_REGS_SVH
`define DFL_REGS_SVH

`define DFL_DATA_WIDTH        16
`define DFL_DEFAULT_LATENCY   64
`define DFL_SEG_MAX_LAT       33
`define DFL_LUTSR_MAX_DEPTH   32
`define DFL_TAP_WIDTH         5

`define DFL_ADDR_WIDTH        8
`define DFL_CTRL_OFFS         8'h00
`define DFL_STATUS_OFFS       8'h04
`define DFL_LATENCY_OFFS      8'h08

`define DFL_CTRL_EN_BIT       0
`define DFL_CTRL_CLR_BIT      1
`define DFL_CTRL_RESET        32'h00000001

`define DFL_STAT_FLUSHED_BIT  0
`define DFL_STAT_OUTVLD_BIT   1
`define DFL_STAT_FULL_BIT     2
`define DFL_STAT_CNT_LSB      8

`endif

// ===== dfl_pkg.sv
// types shared by the fixed-latency delay line modules
package dfl_pkg;
    `include "dfl_regs.svh"

    // one sample word
    typedef logic [`DFL_DATA_WIDTH-1:0] dfl_word_t;

    // occupancy of the two-entry output buffer
    typedef enum logic [1:0] {
        DFL_BUF_EMPTY,
        DFL_BUF_ONE,
        DFL_BUF_TWO
    } dfl_buf_state_t;
endpackage

// ===== dfl_shift_segment.sv
// one lut shift-register segment: circular memory plus registered read flip-flop, or the flip-flop alone for a latency of one
`timescale 1ns/1ps
module dfl_shift_segment
    import dfl_pkg::*;
#(
    parameter int WIDTH   = 17,
    parameter int SEG_LAT = 33
) (
    input  wire logic             clock,
    input  wire logic             clear,
    input  wire logic             advance,
    input  wire logic [WIDTH-1:0] wrData,
    output logic      [WIDTH-1:0] rdData
);
    logic [WIDTH-1:0] rdData_q;     // segment output flip-flop

    assign rdData = rdData_q;

    generate
        if (SEG_LAT <= 1) begin : g_ff
            // flip-flop only segment
            always_ff @(posedge clock) begin
                if (clear) begin
                    rdData_q <= '0;
                end else if (advance) begin
                    rdData_q <= wrData;
                end
            end
        end else begin : g_lutsr
            // tap address: memory gives address plus one cycles, flop adds one more
            localparam int DEPTH = SEG_LAT - 1;
            localparam logic [`DFL_TAP_WIDTH-1:0] TAP = `DFL_TAP_WIDTH'(DEPTH - 1);
            logic [WIDTH-1:0]          mem [0:DEPTH-1]; // contents not clearable
            logic [`DFL_TAP_WIDTH-1:0] ptr_q;           // circular position
            logic [`DFL_TAP_WIDTH-1:0] ptr_d;

            assign ptr_d = (ptr_q == TAP) ? '0 : ptr_q + 1'b1;

            // memory: read the oldest word before overwriting it
            always_ff @(posedge clock) begin
                if (advance) begin
                    mem[ptr_q] <= wrData;
                end
            end

            // pointer and registered read data
            always_ff @(posedge clock) begin
                if (clear) begin
                    ptr_q    <= '0;
                    rdData_q <= '0;
                end else if (advance) begin
                    ptr_q    <= ptr_d;
                    rdData_q <= mem[ptr_q];
                end
            end
        end
    endgenerate
endmodule // dfl_shift_segment

// ===== dfl_skid_buffer.sv
// two-entry output buffer; its main register is the last stage of the delay
`timescale 1ns/1ps
module dfl_skid_buffer
    import dfl_pkg::*;
(
    input  wire logic      clock,
    input  wire logic      clear,
    input  wire logic      pushValid,
    input  wire dfl_word_t pushData,
    output logic           spaceNext,
    output logic           outValid,
    output dfl_word_t      outData,
    input  wire logic      outReady,
    output logic           full
);
    dfl_buf_state_t state_q;     // occupancy
    dfl_buf_state_t state_d;
    dfl_word_t      main_q;      // word on the output
    dfl_word_t      skid_q;      // word parked during a stall
    logic           pop;         // receiver takes the main word

    assign pop       = (state_q != DFL_BUF_EMPTY) && outReady;
    assign outValid  = (state_q != DFL_BUF_EMPTY);
    assign outData   = main_q;
    assign full      = (state_q == DFL_BUF_TWO);
    assign spaceNext = (state_d != DFL_BUF_TWO);

    // next occupancy
    always_comb begin
        case (state_q)
            DFL_BUF_EMPTY: state_d = pushValid ? DFL_BUF_ONE : DFL_BUF_EMPTY;
            DFL_BUF_ONE: begin
                if (pushValid && !pop) begin
                    state_d = DFL_BUF_TWO;
                end else if (!pushValid && pop) begin
                    state_d = DFL_BUF_EMPTY;
                end else begin
                    state_d = DFL_BUF_ONE;
                end
            end
            DFL_BUF_TWO:   state_d = pop ? DFL_BUF_ONE : DFL_BUF_TWO;
            default:       state_d = DFL_BUF_EMPTY;
        endcase
    end

    // storage: the main register loads straight from the chain when free
    always_ff @(posedge clock) begin
        if (clear) begin
            state_q <= DFL_BUF_EMPTY;
            main_q  <= '0;
            skid_q  <= '0;
        end else begin
            state_q <= state_d;
            if (state_q == DFL_BUF_TWO) begin
                if (pop) begin
                    main_q <= skid_q;
                end
            end else if (pushValid && (state_q == DFL_BUF_EMPTY || pop)) begin
                main_q <= pushData;
            end else if (pushValid) begin
                skid_q <= pushData;
            end
        end
    end
endmodule // dfl_skid_buffer

// ===== dfl_delay_line.sv
// fixed-latency delay line with apb control and a two-entry output buffer
`timescale 1ns/1ps

// What this block does
// - output equals input exactly L cycles later
// - output keeps width and rate of input
// - all stages except the lut memory start out as zero
// - reset returns every stage except the lut memory to zero
// - reset wins over enable
// - enable low freezes stages; the output buffer still hands out its held words
// - latency non-negative; zero illegal with enable
// - zero latency is raised to one, a single flip-flop, not a wire
// - latency one is a single flip-flop
// - shift register of L-1 then flip-flop
// - cascade segments of at most 33 cycles
// - segment delay is tap address plus two
// - structural default, behavioural build optional
// - long delays suit a ram with counters
// - clearable line gates output until flushed
module dfl_delay_line
    import dfl_pkg::*;
#(
    parameter int LATENCY    = `DFL_DEFAULT_LATENCY,
    parameter bit BEHAVIORAL = 1'b0
) (
    input  wire logic                       clock,
    input  wire logic                       sys_rst,
    // apb slave
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [`DFL_ADDR_WIDTH-1:0] paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    // sample input
    input  wire logic                       dataInValid,
    input  wire dfl_word_t                  dataIn,
    output logic                            dataInReady,
    // sample output
    output logic                            dataOutValid,
    output dfl_word_t                       dataOut,
    input  wire logic                       dataOutReady
);
    localparam int W = `DFL_DATA_WIDTH;

    // a zero latency would need a wire, but the line always has an enable, so one is the least
    localparam int EFF_LAT   = (LATENCY < 1) ? 1 : LATENCY;
    // the buffer main register is the last flip-flop; the chain supplies the rest
    localparam int CHAIN_LAT = EFF_LAT - 1;
    localparam int NSEG      = (CHAIN_LAT + `DFL_SEG_MAX_LAT - 1) / `DFL_SEG_MAX_LAT;
    localparam int CNT_W     = $clog2(EFF_LAT + 1);

    // latency of segment i: full segments first, remainder last
    function automatic int segLat(input int i);
        int rest;
        rest = CHAIN_LAT - i * `DFL_SEG_MAX_LAT;
        segLat = (rest > `DFL_SEG_MAX_LAT) ? `DFL_SEG_MAX_LAT : rest;
    endfunction

    // ---------------- apb register slave ----------------
    logic        enable_q;          // software shift enable
    logic        enable_d;
    logic        clear_q;           // one-cycle clear pulse
    logic        clear_d;
    logic        pready_q;          // answer strobe
    logic [31:0] prdata_q;          // read data
    logic        pslverr_q;         // unmapped address
    logic        access;            // access phase, not yet answered
    logic        wrStrobe;          // write takes effect this edge
    logic        hitCtrl;           // control register selected
    logic        hitStatus;         // status register selected
    logic        hitLat;            // latency register selected
    logic        hitAny;            // any mapped register
    logic [31:0] rdMux;             // read data selection
    logic [31:0] statusWord;        // live status

    assign access    = psel && penable && !pready_q;
    assign hitCtrl   = (paddr == `DFL_CTRL_OFFS);
    assign hitStatus = (paddr == `DFL_STATUS_OFFS);
    assign hitLat    = (paddr == `DFL_LATENCY_OFFS);
    assign hitAny    = hitCtrl || hitStatus || hitLat;
    // a write lands at the edge where the master sees pready high
    assign wrStrobe  = psel && penable && pready_q && pwrite && hitCtrl;

    assign enable_d = wrStrobe ? pwdata[`DFL_CTRL_EN_BIT] : enable_q;
    assign clear_d  = wrStrobe && pwdata[`DFL_CTRL_CLR_BIT];

    assign rdMux = hitCtrl   ? {31'h00000000, enable_q} :
                   hitStatus ? statusWord :
                   hitLat    ? 32'(EFF_LAT) :
                               32'h00000000;

    // control register and the registered apb answer
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            enable_q  <= 1'(`DFL_CTRL_RESET);
            clear_q   <= 1'b0;
            pready_q  <= 1'b0;
            prdata_q  <= 32'h00000000;
            pslverr_q <= 1'b0;
        end else begin
            enable_q  <= enable_d;
            clear_q   <= clear_d;
            pready_q  <= access;
            prdata_q  <= (access && !pwrite) ? rdMux : 32'h00000000;
            pslverr_q <= access && !hitAny;
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    // ---------------- advance control ----------------
    logic chainRst;                 // synchronous clear of every stage except the lut memory
    logic inReady_q;                // stages advance on this edge
    logic inReady_d;
    logic advance;                  // one shift of every stage
    logic bufSpaceNext;             // buffer still has room next cycle
    logic bufFull;                  // buffer holds two words

    // reset or a clear pulse empties the line whatever the enable says
    assign chainRst = sys_rst || clear_q;

    // freeze on enable low or when the buffer could not take one more word
    assign inReady_d = enable_d && !clear_d && bufSpaceNext;
    assign advance   = inReady_q;

    // registered ready so the input handshake comes from a flip-flop
    always_ff @(posedge clock) begin
        if (chainRst) begin
            inReady_q <= 1'b0;
        end else begin
            inReady_q <= inReady_d;
        end
    end

    assign dataInReady = inReady_q;

    // ---------------- delay chain ----------------
    logic [W:0] chainIn;            // valid flag travels beside the data
    logic [W:0] chainOut;           // word leaving the chain

    assign chainIn = {dataInValid, dataIn};

    generate
        if (CHAIN_LAT == 0) begin : g_wire
            // the chain collapses to a wire; the buffer flop is the one stage
            assign chainOut = chainIn;
        end else if (BEHAVIORAL) begin : g_behav
            // plain resettable registers; synthesis may map or retime them
            logic [W:0] pipe_q [0:CHAIN_LAT-1];
            always_ff @(posedge clock) begin
                if (chainRst) begin
                    for (int i = 0; i < CHAIN_LAT; i++) begin
                        pipe_q[i] <= '0;
                    end
                end else if (advance) begin
                    pipe_q[0] <= chainIn;
                    for (int i = 1; i < CHAIN_LAT; i++) begin
                        pipe_q[i] <= pipe_q[i-1];
                    end
                end
            end
            assign chainOut = pipe_q[CHAIN_LAT-1];
        end else begin : g_struct
            // cascaded lut shift-register segments, each closed by a flip-flop
            logic [W:0] link [0:NSEG];
            assign link[0] = chainIn;
            for (genvar g = 0; g < NSEG; g++) begin : g_seg
                dfl_shift_segment #(
                    .WIDTH   (W + 1),
                    .SEG_LAT (segLat(g))
                ) u_seg (
                    .clock   (clock),
                    .clear   (chainRst),
                    .advance (advance),
                    .wrData  (link[g]),
                    .rdData  (link[g+1])
                );
            end
            assign chainOut = link[NSEG];
        end
    endgenerate

    // ---------------- flush gate ----------------
    logic [CNT_W-1:0] flushCnt_q;   // shifts since the last clear, held once it reaches CHAIN_LAT
    logic             flushed;      // every stage now holds fresh data

    localparam logic [CNT_W-1:0] FLUSH_END = CNT_W'(CHAIN_LAT);

    assign flushed = (flushCnt_q == FLUSH_END);

    // memory stages cannot clear, so count shifts until stale words are gone
    always_ff @(posedge clock) begin
        if (chainRst) begin
            flushCnt_q <= '0;
        end else if (advance && !flushed) begin
            flushCnt_q <= flushCnt_q + 1'b1;
        end
    end

    logic      pushValid;           // word enters the buffer
    dfl_word_t pushData;            // zero until flushed

    assign pushValid = advance && flushed && chainOut[W];
    assign pushData  = flushed ? chainOut[W-1:0] : '0;

    // ---------------- output buffer ----------------
    dfl_skid_buffer u_buf (
        .clock     (clock),
        .clear     (chainRst),
        .pushValid (pushValid),
        .pushData  (pushData),
        .spaceNext (bufSpaceNext),
        .outValid  (dataOutValid),
        .outData   (dataOut),
        .outReady  (dataOutReady),
        .full      (bufFull)
    );

    // ---------------- status ----------------
    assign statusWord = {16'h0000,
                         {(8 - CNT_W){1'b0}}, flushCnt_q,
                         5'h00, bufFull, dataOutValid, flushed};
endmodule // dfl_delay_line

// ===== dfl_sink_model.sv
// downstream receiver model that takes words promptly or stalls at random
`timescale 1ns/1ps
module dfl_sink_model (
    input  wire logic       clock,
    input  wire logic [7:0] stallPct,
    output logic            dataOutReady
);
    // ready from time zero so the first words are not held up
    // per cycle the receiver refuses with the chance given by stallPct
    initial begin
        dataOutReady = 1'b1;
        forever begin
            @(posedge clock);
            dataOutReady <= (($urandom % 100) >= stallPct);
        end
    end
endmodule // dfl_sink_model

// ===== dfl_delay_line_props.sv
// assertions on the ports of the fixed-latency delay line
`timescale 1ns/1ps
`include "dfl_regs.svh"
module dfl_delay_line_props
    import dfl_pkg::*;
#(
    parameter int LATENCY = `DFL_DEFAULT_LATENCY
) (
    input wire logic                       clock,
    input wire logic                       sys_rst,
    input wire logic                       psel,
    input wire logic                       penable,
    input wire logic                       pwrite,
    input wire logic [`DFL_ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0]                pwdata,
    input wire logic [31:0]                prdata,
    input wire logic                       pready,
    input wire logic                       pslverr,
    input wire logic                       dataInValid,
    input wire dfl_word_t                  dataIn,
    input wire logic                       dataInReady,
    input wire logic                       dataOutValid,
    input wire dfl_word_t                  dataOut,
    input wire logic                       dataOutReady
);
    // one clock domain, synchronous reset
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    // access phase still waiting for its answer
    wire accWait = psel && penable && !pready;
    a_one_wait: assert property (accWait |=> pready) else $error("apb answer not after one wait state");
    a_ready_pulse: assert property (pready |=> !pready) else $error("pready longer than one cycle");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("read data outside answer");
    a_err_pair: assert property (pslverr |-> pready) else $error("error without ready");
    a_unmapped_err: assert property (accWait && paddr > `DFL_LATENCY_OFFS |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_lat_read: assert property (accWait && !pwrite && paddr == `DFL_LATENCY_OFFS |=> prdata == LATENCY)
        else $error("latency register wrong");
    a_clr_reads0: assert property (accWait && !pwrite && paddr == `DFL_CTRL_OFFS |=> !prdata[1])
        else $error("clear bit reads back set");
    a_rst_clear: assert property (disable iff (1'b0) sys_rst |=> !dataOutValid && dataOut == '0 && !dataInReady)
        else $error("reset leaves output or ready set");
    a_flush_quiet: assert property ($fell(sys_rst) |-> !dataOutValid [*8])
        else $error("output valid during flush");
    a_ready_return: assert property ($fell(sys_rst) |-> ##[1:2] dataInReady)
        else $error("input ready not back after reset");
    a_out_hold: assert property (dataOutValid && !dataOutReady |=> dataOutValid && $stable(dataOut))
        else $error("stalled word changed");
    // main scenarios
    c_stall: cover property (dataOutValid && !dataOutReady);
    c_err: cover property (pslverr);
    c_refuse: cover property (!dataInReady && dataOutValid);
endmodule // dfl_delay_line_props

bind dfl_delay_line dfl_delay_line_props #(.LATENCY(LATENCY)) u_props (
    .clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dataInValid(dataInValid), .dataIn(dataIn), .dataInReady(dataInReady),
    .dataOutValid(dataOutValid), .dataOut(dataOut), .dataOutReady(dataOutReady)
);

// ===== dfl_delay_line_tb.sv
// self-checking bench of the fixed-latency delay line
`timescale 1ns/1ps
`include "dfl_regs.svh"
module dfl_delay_line_tb
    import dfl_pkg::*;
();
    localparam int LAT = 64;             // latency under test, two cascaded segments
    typedef struct { dfl_word_t d; int idx; } dfl_note_t;
    logic        clock = 1'b0;
    logic        sys_rst = 1'b1;         // driven as a plain boolean level
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, er;
    logic        dataInValid = 1'b0, dataInReady, dataOutValid, dataOutReady;
    dfl_word_t   dataIn = '0, dataOut;
    logic [7:0]  stallPct = 8'h00;       // receiver refusal chance
    dfl_note_t   noteQ[$], note;         // expected words in order
    int          shiftCnt = 0, cyc = 0, error_cnt = 0, checked = 0, k;
    bit          chkLat = 1'b0;          // exact latency is checked only with a prompt receiver

    dfl_delay_line #(.LATENCY(LAT), .BEHAVIORAL(1'b0)) uut (
        .clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .dataInValid(dataInValid), .dataIn(dataIn), .dataInReady(dataInReady),
        .dataOutValid(dataOutValid), .dataOut(dataOut), .dataOutReady(dataOutReady)
    );
    dfl_sink_model u_sink (.clock(clock), .stallPct(stallPct), .dataOutReady(dataOutReady));

    // 50 ns clock
    always #25 clock = ~clock;

    // cycle and shift counters, and the hang limit
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (dataInReady === 1'b1) shiftCnt <= shiftCnt + 1;
        if (cyc == 20000) begin
            error_cnt++;
            print_verdict();
        end
    end

    // compare of sample words
    task automatic cmpw(input dfl_word_t got, input dfl_word_t exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // compare of register values, flags and counts
    task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one apb transfer, held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // read and compare data and error response
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic experr);
        apb(1'b0, a, 32'h0);
        cmp32(rd, exp);
        cmp32({31'h0, er}, {31'h0, experr});
    endtask

    // upstream: registered samples for n shifts, pct percent of them valid
    task automatic send(input int n, input int pct);
        int s;
        s = 0;
        while (s < n) begin
            dataInValid <= (($urandom % 100) < pct); // registered source
            dataIn <= dfl_word_t'($urandom);
            @(posedge clock);
            if (dataInReady === 1'b1) begin
                s++;
                if (dataInValid === 1'b1) noteQ.push_back('{dataIn, shiftCnt});
            end
        end
        dataInValid <= 1'b0;
        @(posedge clock);
    endtask

    // receiver side: every accepted word is checked against the oldest note
    always @(posedge clock) begin
        if (sys_rst === 1'b0 && dataOutValid === 1'b1 && dataOutReady === 1'b1) begin
            if (noteQ.size() == 0) cmp32(32'h1, 32'h0);
            else begin
                note = noteQ.pop_front();
                cmpw(dataOut, note.d);
                if (chkLat) cmp32(32'(shiftCnt - note.idx), 32'(LAT));
            end
        end
    end

    // verdict and end of run
    task print_verdict;
        if (error_cnt == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // main sequence
    initial begin
        void'($urandom(32'h9934));
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        // register reset values, read-only and unmapped places
        rdchk(`DFL_CTRL_OFFS, `DFL_CTRL_RESET, 1'b0);
        rdchk(`DFL_LATENCY_OFFS, 32'(LAT), 1'b0);
        apb(1'b1, `DFL_LATENCY_OFFS, 32'h5);
        rdchk(`DFL_LATENCY_OFFS, 32'(LAT), 1'b0);
        rdchk(8'h0C, 32'h0, 1'b1);
        apb(1'b1, 8'h0C, 32'hFFFFFFFF);
        rdchk(`DFL_CTRL_OFFS, 32'h1, 1'b0);
        // flush, then a dense stream with bubbles
        send(LAT, 0);
        chkLat = 1'b1;
        send(150, 85);
        // freeze by enable low, then resume
        apb(1'b1, `DFL_CTRL_OFFS, 32'h0);
        repeat (3) @(posedge clock);
        cmp32({31'h0, dataInReady}, 32'h0);
        rdchk(`DFL_CTRL_OFFS, 32'h0, 1'b0);
        apb(1'b1, `DFL_CTRL_OFFS, 32'h1);
        send(100, 90);
        // receiver stalls until the buffer refuses, then drains slowly
        chkLat = 1'b0;
        stallPct <= 8'd100;
        repeat (LAT + 1) @(posedge clock);
        repeat (3) @(posedge clock);
        cmp32({31'h0, dataInReady}, 32'h0);
        cmp32({31'h0, dataOutValid}, 32'h1);
        stallPct <= 8'd50;
        send(120, 80);
        // clear together with enable while words are in flight
        stallPct <= 8'd0;
        apb(1'b1, `DFL_CTRL_OFFS, 32'h0);
        repeat (4) @(posedge clock);
        apb(1'b1, `DFL_CTRL_OFFS, 32'h3);
        noteQ.delete();
        rdchk(`DFL_CTRL_OFFS, 32'h1, 1'b0);
        send(LAT, 0);
        chkLat = 1'b1;
        send(60, 100);
        // reset in mid-stream
        send(30, 100);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clock);
        noteQ.delete();
        sys_rst <= 1'b0;
        @(posedge clock);
        cmp32({31'h0, dataOutValid}, 32'h0);
        rdchk(`DFL_CTRL_OFFS, `DFL_CTRL_RESET, 1'b0);
        send(LAT, 0);
        send(50, 100);
        // drain and confirm nothing is missing
        send(LAT + 4, 0);
        k = 0;
        while (noteQ.size() != 0 && k < 300) begin
            @(posedge clock);
            k++;
        end
        cmp32(32'(noteQ.size()), 32'h0);
        rdchk(`DFL_STATUS_OFFS, 32'h00003F01, 1'b0);
        print_verdict();
    end
endmodule // dfl_delay_line_tb
